// >>> pkg/ppwm_pkg.sv
// package: constants and carriers for the pin waveform generator
package ppwm_pkg;
  localparam int CLK_HZ = 250000000;
  localparam int TICK_HZ = 1000000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int SQ_MAX_HZ = 4000000;
  // rounded up so the shortest legal half period never passes the ceiling
  localparam int SQ_MIN_HALF_CYCLES = (CLK_HZ + 2 * SQ_MAX_HZ - 1) / (2 * SQ_MAX_HZ);
  localparam int NUM_PINS = 16;
  localparam int PERIOD_W = 16;
  localparam int SQ_W = 24;
  localparam logic [7:0] SQ_DUTY_RESET = 8'h80;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 16'h03e8;
  localparam logic [PERIOD_W-1:0] DUTY_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ppwm_fn_gpio = 2'b00,
    ppwm_fn_pwm = 2'b01,
    ppwm_fn_square = 2'b10
  } ppwm_fn_type;

  typedef struct packed {
    ppwm_fn_type fn;
    logic gpio_level;
    logic [PERIOD_W-1:0] pwm_duty;
    logic [7:0] sq_duty;
  } ppwm_pin_cfg_type;
endpackage : ppwm_pkg

// >>> src/ppwm_channel.sv
// module: one pin's pwm / square-wave comparator
`timescale 1ns/1ps
`default_nettype none
module ppwm_channel (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // shared timebases
  input wire logic [ppwm_pkg::PERIOD_W-1:0] pwm_count,
  input wire logic [7:0] sq_phase,
  input wire logic sq_run,
  // configuration
  input wire ppwm_pkg::ppwm_pin_cfg_type cfg,
  // pin
  output logic pin_out
);
  import ppwm_pkg::*;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
    end else begin
      case (cfg.fn)
        ppwm_fn_pwm: pin_out <= (pwm_count < cfg.pwm_duty);
        ppwm_fn_square: begin
          // stopped square wave parks low
          pin_out <= sq_run && (sq_phase < cfg.sq_duty);
        end
        default: pin_out <= cfg.gpio_level;
      endcase
    end
  end
endmodule : ppwm_channel
`default_nettype wire

// >>> src/ppwm_top.sv
// module: pin pwm and shared square-wave generator, sixteen pins
// What this block does
// - pwm selectable on any of sixteen pins
// - pwm up to 500 kHz (2 us period), duty 0-100%
// - duty resolution equals period in microseconds
// - square wave on sixteen pins, one frequency
// - separate square-wave duty per pin
// - square frequency 0 to 4 MHz, 50% default
`timescale 1ns/1ps
`default_nettype none
module ppwm_top #(
  parameter int NUM_PINS = ppwm_pkg::NUM_PINS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pwm timebase: period in 1 us ticks, 0 or 1 stops the counter
  input wire logic [ppwm_pkg::PERIOD_W-1:0] pwm_period,
  // square wave: half period in core clocks, 0 means stopped
  input wire logic [ppwm_pkg::SQ_W-1:0] sq_half_cycles,
  // per-pin setup
  input wire ppwm_pkg::ppwm_pin_cfg_type [NUM_PINS-1:0] pin_cfg,
  // status
  output logic sq_running,
  output logic [ppwm_pkg::PERIOD_W-1:0] pwm_position,
  // pins
  output logic [NUM_PINS-1:0] general_signal_pin
);
  import ppwm_pkg::*;

  // square timebase: off, or playing the first or second half of a period
  typedef enum logic [1:0] {
    ppwm_sq_stopped = 2'b00,
    ppwm_sq_mark = 2'b01,
    ppwm_sq_space = 2'b10
  } ppwm_sq_state_type;

  logic [7:0] tick_div;
  logic tick;
  logic [PERIOD_W-1:0] pwm_count;
  logic [SQ_W-1:0] sq_half_eff;
  logic [SQ_W-1:0] sq_div;
  ppwm_sq_state_type sq_state;
  logic [7:0] sq_phase;
  logic sq_run;
  logic [NUM_PINS-1:0] pin_level;

  // below a 2 us period the pwm would pass 500 kHz, so the counter rests
  function automatic logic pwm_halted(input logic [PERIOD_W-1:0] period);
    return period < 16'h0002;
  endfunction : pwm_halted

  // last microsecond of the period
  function automatic logic pwm_last(
    input logic [PERIOD_W-1:0] count,
    input logic [PERIOD_W-1:0] period
  );
    return count >= period - 16'h0001;
  endfunction : pwm_last

  // settings that would pass 4 MHz are raised to the shortest legal half period
  function automatic logic [SQ_W-1:0] sq_clamp(input logic [SQ_W-1:0] half);
    logic [SQ_W-1:0] result;
    result = half;
    if (half != '0 && half < SQ_W'(SQ_MIN_HALF_CYCLES)) begin
      result = SQ_W'(SQ_MIN_HALF_CYCLES);
    end
    return result;
  endfunction : sq_clamp

  // last core clock of a half period; a zero setting ends it at once
  function automatic logic sq_last(
    input logic [SQ_W-1:0] pos,
    input logic [SQ_W-1:0] half
  );
    return (half == '0) || (pos >= half - SQ_W'(1));
  endfunction : sq_last

  // position inside a half period scaled to 0..127; a divider is costly,
  // but it keeps the per-pin duty independent of the frequency setting
  function automatic logic [6:0] sq_fine(
    input logic [SQ_W-1:0] pos,
    input logic [SQ_W-1:0] half
  );
    logic [31:0] scaled;
    scaled = 32'h0000_0000;
    if (half != '0) begin
      scaled = ({8'h00, pos} * 32'h0000_0080) / {8'h00, half};
    end
    return scaled[6:0];
  endfunction : sq_fine

  // 1 us tick from the 250 MHz clock
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_div <= 8'h00;
    end else if (tick_div == 8'(TICK_CYCLES - 1)) begin
      tick_div <= 8'h00;
    end else begin
      tick_div <= tick_div + 8'h01;
    end
  end

  // tick is registered so the counter sees a clean one-clock pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= (tick_div == 8'(TICK_CYCLES - 1));
    end
  end

  // period counter in microseconds gives 1:N resolution
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwm_count <= '0;
    end else if (pwm_halted(pwm_period)) begin
      pwm_count <= '0;
    end else if (pwm_count >= pwm_period) begin
      // a shortened period must not leave the count above it for a whole tick
      pwm_count <= '0;
    end else if (tick) begin
      if (pwm_last(pwm_count, pwm_period)) begin
        pwm_count <= '0;
      end else begin
        pwm_count <= pwm_count + 16'h0001;
      end
    end
  end

  // clamp so the square wave never exceeds 4 MHz
  always_comb begin
    sq_half_eff = sq_clamp(sq_half_cycles);
  end

  // one shared state machine drives every square pin at one frequency
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sq_state <= ppwm_sq_stopped;
    end else begin
      case (sq_state)
        ppwm_sq_stopped: begin
          if (sq_half_eff != '0) begin
            sq_state <= ppwm_sq_mark;
          end
        end
        ppwm_sq_mark: begin
          if (sq_half_eff == '0) begin
            sq_state <= ppwm_sq_stopped;
          end else if (sq_last(sq_div, sq_half_eff)) begin
            sq_state <= ppwm_sq_space;
          end
        end
        ppwm_sq_space: begin
          if (sq_half_eff == '0) begin
            sq_state <= ppwm_sq_stopped;
          end else if (sq_last(sq_div, sq_half_eff)) begin
            sq_state <= ppwm_sq_mark;
          end
        end
        default: begin
          sq_state <= ppwm_sq_stopped;
        end
      endcase
    end
  end

  // core clocks spent in the current half period
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sq_div <= '0;
    end else if (sq_state == ppwm_sq_stopped || sq_last(sq_div, sq_half_eff)) begin
      sq_div <= '0;
    end else begin
      sq_div <= sq_div + SQ_W'(1);
    end
  end

  // phase walks 0..255 once per period; a pin's 8-bit duty compares against it,
  // so 8'h80 gives the 50% mark-space
  // limitation: at the top frequencies a half period has fewer than 128 clocks,
  // so duty steps coarsen there
  assign sq_phase = {sq_state == ppwm_sq_space, sq_fine(sq_div, sq_half_eff)};
  assign sq_run = (sq_state != ppwm_sq_stopped);

  // each pin picks its own function and duty
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    ppwm_channel u_channel (
      .core_clk(core_clk),
      .reset(reset),
      .pwm_count(pwm_count),
      .sq_phase(sq_phase),
      .sq_run(sq_run),
      .cfg(pin_cfg[i]),
      .pin_out(pin_level[i])
    );
  end

  // outputs straight from flip-flops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      general_signal_pin <= '0;
    end else begin
      general_signal_pin <= pin_level;
    end
  end

  // status lags its timebase by one clock
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sq_running <= 1'b0;
    end else begin
      sq_running <= sq_run;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwm_position <= '0;
    end else begin
      pwm_position <= pwm_count;
    end
  end
endmodule : ppwm_top
`default_nettype wire

// >>> tb/ppwm_top_asserts.sv
// checker: pin waveform timing relations
`timescale 1ns/1ps
`default_nettype none
module ppwm_asserts #(parameter int NUM_PINS = 16) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [ppwm_pkg::PERIOD_W-1:0] pwm_period,
  input wire logic [ppwm_pkg::SQ_W-1:0] sq_half_cycles,
  input wire ppwm_pkg::ppwm_pin_cfg_type [NUM_PINS-1:0] pin_cfg,
  input wire logic sq_running,
  input wire logic [ppwm_pkg::PERIOD_W-1:0] pwm_position,
  input wire logic [NUM_PINS-1:0] general_signal_pin
);
  import ppwm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // four quiet cycles cover the two-stage pin pipeline plus reset release
  sequence q;
    ($stable(pin_cfg) && $stable(pwm_period) && $stable(sq_half_cycles)) [*4];
  endsequence
  a_sq_idle: assert property (sq_half_cycles == 0 [*4] |-> !sq_running)
    else $error("square timebase runs at zero setting");
  a_sq_run: assert property (sq_half_cycles != 0 [*4] |-> sq_running)
    else $error("square timebase not running");
  a_sq_hold: assert property (q ##0 (pin_cfg[0].fn == ppwm_fn_square &&
    sq_half_cycles == 0) |-> !general_signal_pin[0]) else $error("stopped square pin toggles");
  a_pwm_full: assert property (q ##0 (pin_cfg[0].fn == ppwm_fn_pwm && pwm_period > 1 &&
    pin_cfg[0].pwm_duty >= pwm_period) |-> general_signal_pin[0])
    else $error("full duty pin low");
  a_pwm_zero: assert property (q ##0 (pin_cfg[0].fn == ppwm_fn_pwm &&
    pin_cfg[0].pwm_duty == 0) |-> !general_signal_pin[0]) else $error("zero duty pin high");
  a_shared_base: assert property (q ##0 (pin_cfg[15] == pin_cfg[0])
    |-> general_signal_pin[15] == general_signal_pin[0])
    else $error("pins with equal setup differ");
  a_halt_count: assert property (pwm_period < 2 [*4] |-> pwm_position == 0)
    else $error("stopped counter moves");
endmodule : ppwm_asserts
`default_nettype wire

// >>> tb/ppwm_top_tb_top.sv
// testbench: pwm and square pins against an integer model
`timescale 1ns/1ps
`default_nettype none
module ppwm_top_tb_top;
  import ppwm_pkg::*;
  logic core_clk = 0;
  logic reset = 1;
  logic [PERIOD_W-1:0] pwm_period = 0;
  logic [SQ_W-1:0] sq_half_cycles = 0;
  ppwm_pin_cfg_type [NUM_PINS-1:0] pin_cfg = '0;
  logic sq_running;
  logic [PERIOD_W-1:0] pwm_position;
  logic [NUM_PINS-1:0] general_signal_pin;
  int bad_count = 0, num_checks = 0, cycles = 0, hi0, hi1, top, p, d, h;
  always #2 core_clk = ~core_clk;
  ppwm_top dut_u (.core_clk(core_clk), .reset(reset), .pwm_period(pwm_period),
    .sq_half_cycles(sq_half_cycles), .pin_cfg(pin_cfg), .sq_running(sq_running),
    .pwm_position(pwm_position), .general_signal_pin(general_signal_pin));
  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(string name, int exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check
  task automatic setup(ppwm_fn_type f, int per, int dut, int half, int sd1);
    ppwm_pin_cfg_type [NUM_PINS-1:0] a;
    @(posedge core_clk);
    a = {NUM_PINS{ppwm_pin_cfg_type'{f, 1'b0, dut[PERIOD_W-1:0], SQ_DUTY_RESET}}};
    a[1].sq_duty = sd1[7:0];
    pwm_period <= per[PERIOD_W-1:0];
    sq_half_cycles <= half[SQ_W-1:0];
    pin_cfg <= a;
  endtask : setup
  // one whole period is skipped first so an old count cannot leak in
  task automatic measure(int n);
    repeat (n + 8) @(posedge core_clk);
    hi0 = 0;
    hi1 = 0;
    top = 0;
    repeat (n) begin
      @(negedge core_clk);
      hi0 += (general_signal_pin[0] === 1'b1);
      hi1 += (general_signal_pin[1] === 1'b1);
      if (pwm_position > top) top = pwm_position;
    end
  endtask : measure
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    p = $urandom(30337);
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      p = (k == 0) ? 2 : 2 + $urandom % 9;
      d = (k == 1) ? 0 : $urandom % (p + 2);
      setup(ppwm_fn_pwm, p, d, 0, 8'h80);
      measure(p * TICK_CYCLES);
      check("pwm_high", (d > p ? p : d) * TICK_CYCLES, hi0);
      check("pwm_top", p - 1, top);
    end
    for (int k = 0; k < 4; k++) begin
      h = (k == 0) ? 0 : 4 * (8 + $urandom % 43);
      setup(ppwm_fn_square, 0, 0, h, 8'h40);
      measure(h ? 2 * h : 64);
      check("sq_pin0", h, hi0);
      check("sq_pin1", h / 2, hi1);
    end
    finish_test();
  end
endmodule : ppwm_top_tb_top
bind ppwm_top ppwm_asserts #(.NUM_PINS(NUM_PINS)) chk_u (.core_clk(core_clk), .reset(reset),
  .pwm_period(pwm_period), .sq_half_cycles(sq_half_cycles), .pin_cfg(pin_cfg),
  .sq_running(sq_running), .pwm_position(pwm_position), .general_signal_pin(general_signal_pin));
`default_nettype wire
